// ===== rtl/flash_link_pkg.sv
// Constants and types for the serial flash link front end
// Overview of operation
// - Sample input on rising, launch output falling
// - Idle clock low means Mode 0, high Mode 3
// - Output valid within clock low at 66MHz; here so_out follows the falling clock by two to three system clocks
// - High-speed timing: host captures one cycle later
// - Busy within 100 ns after select rises
// - Write protect follows its pin within 1 us
// - Power-down entry 3 us, resume 35 us
// - Buffer transfer or compare within 200 us
// - Erase-program 40ms, program 6ms, erase 35ms
// - Block 100ms, sector 1.3s, chip 25s erase
// - Mode chosen each select fall; reset gives Mode 3
package flash_link_pkg;

  // ****************************************
  // Clock and timing figures
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10; // System clock period
  localparam int unsigned SYNC_LAT = 4; // Pin to detected edge, worst case
  localparam int unsigned T_CSB_NS = 100; // Select high to busy
  localparam int unsigned T_WPE_US = 1; // Protect enable
  localparam int unsigned T_EDPD_US = 3; // Enter deep power-down
  localparam int unsigned T_RDPD_US = 35; // Resume to standby
  localparam int unsigned T_XFR_US = 200; // Page transfer / compare
  localparam int unsigned T_EP_MS = 40; // Erase and program
  localparam int unsigned T_P_MS = 6; // Program only
  localparam int unsigned T_PE_MS = 35; // Page erase
  localparam int unsigned T_BE_MS = 100; // Block erase
  localparam real T_SE_S = 1.3; // Sector erase
  localparam int unsigned T_CE_S = 25; // Chip erase

  // Longest times round down to whole cycles
  localparam int unsigned CSB_CYC = T_CSB_NS / CLK_PERIOD_NS;
  localparam int unsigned WPE_CYC = (T_WPE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned EDPD_CYC = (T_EDPD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RDPD_CYC = (T_RDPD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned XFR_CYC = (T_XFR_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned EP_CYC = (T_EP_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned P_CYC = (T_P_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PE_CYC = (T_PE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned BE_CYC = (T_BE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned SE_CYC =
    int'($floor(T_SE_S * 1.0e9 / real'(CLK_PERIOD_NS)));
  localparam int unsigned CE_CYC =
    32'((64'(T_CE_S) * 64'd1000000000) / 64'(CLK_PERIOD_NS));

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_MODE3 = 1'b1; // Mode 3 after reset
  localparam logic [2:0] RST_BIT_CNT = 3'h0; // Bit counters

  // ****************************************
  // Internal operations started at select rise
  // ****************************************
  typedef enum logic [3:0] {
    OP_XFR = 4'h0, // Page to buffer transfer
    OP_COMP = 4'h1, // Page to buffer compare
    OP_ERASE_PROG = 4'h2, // Page erase and program
    OP_PROG = 4'h3, // Page program
    OP_PAGE_ERASE = 4'h4, // Page erase
    OP_BLOCK_ERASE = 4'h5, // Block erase
    OP_SECTOR_ERASE = 4'h6, // Sector erase
    OP_CHIP_ERASE = 4'h7, // Chip erase
    OP_DPD = 4'h8, // Enter deep power-down
    OP_RESUME = 4'h9 // Resume from deep power-down
  } op_t;

  // Operation request from the command decoder
  typedef struct packed {
    logic valid; // One-cycle request pulse
    op_t code; // Operation to start
  } op_req_t;

  // Synchronised pin group
  typedef struct packed {
    logic sel_n; // Chip select, active low
    logic sck; // Serial clock
    logic si; // Serial input
    logic wp_n; // Write protect, active low
  } pins_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, // Standby
    ST_BUSY = 5'h02, // Self-timed operation running
    ST_DPD_ENTER = 5'h04, // Going to deep power-down
    ST_DEEP = 5'h08, // Deep power-down
    ST_DPD_EXIT = 5'h10 // Returning to standby
  } state_t;

endpackage

// ===== rtl/serial_flash_link_timing.sv
// Serial target front end with self-timed operation sequencer
`timescale 1ns/1ps
module serial_flash_link_timing
  import flash_link_pkg::*;
#(
  parameter int unsigned XFR_CYCLES = XFR_CYC, // Transfer / compare
  parameter int unsigned EP_CYCLES = EP_CYC, // Erase and program
  parameter int unsigned P_CYCLES = P_CYC, // Program only
  parameter int unsigned PE_CYCLES = PE_CYC, // Page erase
  parameter int unsigned BE_CYCLES = BE_CYC, // Block erase
  parameter int unsigned SE_CYCLES = SE_CYC, // Sector erase
  parameter int unsigned CE_CYCLES = CE_CYC // Chip erase
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire op_req_t op_req_in,
  input wire logic [7:0] tx_byte_in,
  output logic so_out,
  output logic so_oe_out,
  output logic mode3_out,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic busy_n_out,
  output logic protect_out,
  output logic power_down_out
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  pins_t pin_meta; // First stage, read only by second
  pins_t pin_sync; // Second stage, safe to use
  logic sck_d; // Previous synced clock
  logic sel_n_d; // Previous synced select

  // Two flops on every pin
  always_ff @(posedge clock_in) begin
    pin_meta <= {sel_n_in, sck_in, si_in, wp_n_in};
    pin_sync <= pin_meta;
    sck_d <= pin_sync.sck;
    sel_n_d <= pin_sync.sel_n;
  end

  wire selected = ~pin_sync.sel_n; // Frame in progress
  wire sck_rise = pin_sync.sck & ~sck_d & selected;
  wire sck_fall = ~pin_sync.sck & sck_d & selected;
  wire sel_fall = ~pin_sync.sel_n & sel_n_d; // Frame start
  wire sel_rise = pin_sync.sel_n & ~sel_n_d; // Frame end

  // ****************************************
  // Receive shifter
  // ****************************************
  logic [7:0] rx_shift; // Incoming bits
  logic [2:0] rx_cnt; // Bits of current byte
  wire [7:0] rx_next = {rx_shift[6:0], pin_sync.si}; // MSB first

  // Sample on rising clock
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !selected) begin
      rx_cnt <= RST_BIT_CNT;
      rx_shift <= 8'h00;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= sck_rise && (rx_cnt == 3'h7);
      if (sck_rise) begin
        rx_shift <= rx_next;
        rx_cnt <= rx_cnt + 3'h1;
      end
    end
  end

  // Whole byte handed on
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rx_byte_out <= 8'h00;
    end else if (sck_rise && (rx_cnt == 3'h7)) begin
      rx_byte_out <= rx_next;
    end
  end

  // ****************************************
  // Mode selection and transmit shifter
  // ****************************************
  logic [7:0] tx_shift; // Remaining outgoing bits
  logic [2:0] tx_cnt; // Falling edges within byte

  // Mode follows idle clock at select fall
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      mode3_out <= RST_MODE3;
    end else if (sel_fall) begin
      mode3_out <= pin_sync.sck;
    end
  end

  // Launch on falling clock; Mode 0 has no lead falling edge
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_cnt <= RST_BIT_CNT;
      tx_shift <= 8'h00;
      so_out <= 1'b0;
    end else if (sel_fall) begin
      tx_cnt <= {2'b00, ~pin_sync.sck};
    end else if (sck_fall) begin
      tx_cnt <= tx_cnt + 3'h1;
      if (tx_cnt == 3'h0) begin
        so_out <= tx_byte_in[7];
        tx_shift <= {tx_byte_in[6:0], 1'b0};
      end else begin
        so_out <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Drive only inside a frame
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= selected;
    end
  end

  // ****************************************
  // Write protect
  // ****************************************
  // Synced pin reaches output in three cycles, far under 1 us
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      protect_out <= 1'b0;
    end else begin
      protect_out <= ~pin_sync.wp_n;
    end
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  state_t state; // Sequencer state
  state_t next_state; // Its next value
  op_req_t pending; // Operation armed for select rise
  logic [31:0] cnt; // Remaining cycles
  logic [31:0] next_cnt; // Its next value

  // Full cycles to run; cnt_done takes off the pin latency already spent
  function automatic logic [31:0] dur_of(input op_t op);
    logic [31:0] c;
    c = 32'(XFR_CYCLES);
    case (op)
      OP_ERASE_PROG: c = 32'(EP_CYCLES);
      OP_PROG: c = 32'(P_CYCLES);
      OP_PAGE_ERASE: c = 32'(PE_CYCLES);
      OP_BLOCK_ERASE: c = 32'(BE_CYCLES);
      OP_SECTOR_ERASE: c = 32'(SE_CYCLES);
      OP_CHIP_ERASE: c = 32'(CE_CYCLES);
      default: c = c;
    endcase
    return c;
  endfunction

  // Program and erase kinds that protect blocks
  function automatic logic is_write(input op_t op);
    return (op == OP_ERASE_PROG) || (op == OP_PROG) ||
           (op == OP_PAGE_ERASE) || (op == OP_BLOCK_ERASE) ||
           (op == OP_SECTOR_ERASE) || (op == OP_CHIP_ERASE);
  endfunction

  wire op_ok = pending.valid && !(protect_out && is_write(pending.code));
  wire start_op = sel_rise && op_ok; // Frame end launches it
  wire cnt_done = (cnt <= 32'(SYNC_LAT));

  // Arm request during frame, drop at frame boundaries
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || sel_fall || sel_rise) begin
      pending <= '0;
    end else if (op_req_in.valid && selected) begin
      pending <= op_req_in;
    end
  end

  // Next state and count
  always_comb begin
    next_state = state;
    next_cnt = (cnt == 32'h0) ? cnt : cnt - 32'h1;
    case (state)
      ST_IDLE: begin
        if (start_op && pending.code == OP_DPD) begin
          next_state = ST_DPD_ENTER;
          next_cnt = 32'(EDPD_CYC);
        end else if (start_op && pending.code != OP_RESUME) begin
          next_state = ST_BUSY;
          next_cnt = dur_of(pending.code);
        end
      end
      ST_BUSY: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_DPD_ENTER: begin
        if (cnt_done) begin
          next_state = ST_DEEP;
        end
      end
      ST_DEEP: begin
        if (start_op && pending.code == OP_RESUME) begin
          next_state = ST_DPD_EXIT;
          next_cnt = 32'(RDPD_CYC);
        end
      end
      ST_DPD_EXIT: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = 32'h0;
      end
    endcase
  end

  // State registers and outputs
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      cnt <= 32'h0;
      busy_n_out <= 1'b1;
      power_down_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      busy_n_out <= (next_state != ST_BUSY);
      power_down_out <= (next_state == ST_DEEP) ||
                        (next_state == ST_DPD_EXIT);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] busy_age; // Cycles busy so far
  logic [31:0] busy_lim; // Allowed for running operation
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || busy_n_out) begin
      busy_age <= 32'h0;
    end else begin
      busy_age <= busy_age + 32'h1;
    end
    if (start_op) begin
      busy_lim <= dur_of(pending.code);
    end
  end

  sequence s_frame_start;
    sel_fall;
  endsequence

  property p_sample;
    @(posedge clock_in) disable iff (!rst_n_in)
      sck_rise |=> rx_shift[0] == $past(pin_sync.si);
  endproperty
  a_sample: assert property (p_sample)
    else $error("input bit not taken on rising clock");

  property p_launch;
    @(posedge clock_in) disable iff (!rst_n_in)
      $changed(so_out) |-> $past(sck_fall);
  endproperty
  a_launch: assert property (p_launch)
    else $error("output bit changed off a falling clock");

  property p_mode;
    @(posedge clock_in) disable iff (!rst_n_in)
      s_frame_start |=> mode3_out == $past(pin_sync.sck);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode not taken from idle clock");

  property p_mode_reset;
    @(posedge clock_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> mode3_out;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode after reset is not Mode 3");

  property p_hiz;
    @(posedge clock_in) disable iff (!rst_n_in)
      $past(pin_sync.sel_n) |-> !so_oe_out;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven while deselected");

  property p_busy_soon;
    @(posedge clock_in) disable iff (!rst_n_in)
      (start_op && state == ST_IDLE && pending.code != OP_DPD &&
       pending.code != OP_RESUME) |-> ##[1:2] !busy_n_out;
  endproperty
  a_busy_soon: assert property (p_busy_soon)
    else $error("busy late after select rise");

  property p_protect;
    @(posedge clock_in) disable iff (!rst_n_in)
      $fell(pin_sync.wp_n) |-> ##[1:2] protect_out;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect late after pin low");

  property p_busy_bound;
    @(posedge clock_in) disable iff (!rst_n_in)
      !busy_n_out |-> busy_age < busy_lim;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("operation overran its time");

  property p_dpd;
    @(posedge clock_in) disable iff (!rst_n_in)
      (state == ST_DPD_ENTER) |-> cnt <= 32'(EDPD_CYC);
  endproperty
  a_dpd: assert property (p_dpd)
    else $error("power-down entry count too long");

endmodule // serial_flash_link_timing

// ===== tb/flash_host_model.sv
// Host controller model driving select, clock and data in whole frames, and clock and data toggles while deselected
`timescale 1ns/1ps
module flash_host_model (
  output logic sel_n_out,
  output logic sck_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  // ****************************************
  // Pin state at time zero
  // ****************************************
  initial begin
    sel_n_out = 1'b1; // Deselected before reset ends
    sck_out = 1'b1; // Parked high before the first frame
    si_out = 1'b0; // Data line start level
  end

  // ****************************************
  // Frame tasks
  // ****************************************
  // Park the clock at the idle level, then select
  task automatic start_frame(input logic idle_high);
    sck_out = idle_high;
    #60; // Select stays high long enough between frames
    sel_n_out = 1'b0;
    #60;
  endtask

  // One byte each way, 125 ns clock well under the limits
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      #31;
      si_out = tx[i]; // Most significant bit first
      #31.5;
      rx[i] = so_oe_in ? so_in : 1'bx; // Read in low phase
      sck_out = 1'b1;
      #62.5;
    end
  endtask

  // Close the frame; Mode 0 ends with a last falling edge
  task automatic end_frame(input logic idle_high);
    if (!idle_high) begin
      sck_out = 1'b0;
      #62.5;
    end
    sel_n_out = 1'b1;
    si_out = ~si_out; // Released line shows no stale bit
  endtask

  // Clock and data activity while deselected
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sck_out = ~sck_out;
      si_out = ~si_out;
      #62.5;
    end
  endtask
endmodule // flash_host_model

// ===== tb/serial_flash_link_timing_tb_top.sv
// Self-checking bench for the serial flash link front end
`timescale 1ns/1ps
module serial_flash_link_timing_tb_top
  import flash_link_pkg::*;
;
  // ****************************************
  // Signals and parameters
  // ****************************************
  localparam int XFR_T = 60; // Shortened transfer count
  localparam int EP_T = 120; // Shortened erase and program
  localparam int P_T = 70; // Shortened program
  localparam int PE_T = 110; // Shortened page erase
  localparam int BE_T = 130; // Shortened block erase
  localparam int SE_T = 150; // Shortened sector erase
  localparam int CE_T = 170; // Shortened chip erase
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sel_n, sck, si, wp_n_in = 1'b1;
  op_req_t op_req_in = '0;
  logic [7:0] tx_byte_in = 8'h00;
  logic so_out, so_oe_out, mode3_out, rx_valid_out;
  logic busy_n_out, protect_out, power_down_out;
  logic [7:0] rx_byte_out;
  int err_count = 0;
  int check_count = 0;
  int rx_count = 0; // Completed bytes seen

  // ****************************************
  // Clock, instances, byte counter
  // ****************************************
  always #5 clock_in = ~clock_in;

  serial_flash_link_timing #(.XFR_CYCLES(XFR_T), .EP_CYCLES(EP_T),
    .P_CYCLES(P_T), .PE_CYCLES(PE_T), .BE_CYCLES(BE_T),
    .SE_CYCLES(SE_T), .CE_CYCLES(CE_T)) u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .sel_n_in(sel_n),
    .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in), .op_req_in(op_req_in),
    .tx_byte_in(tx_byte_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .mode3_out(mode3_out), .rx_byte_out(rx_byte_out),
    .rx_valid_out(rx_valid_out), .busy_n_out(busy_n_out),
    .protect_out(protect_out), .power_down_out(power_down_out));

  flash_host_model u_host (.sel_n_out(sel_n), .sck_out(sck),
    .si_out(si), .so_in(so_out), .so_oe_in(so_oe_out));

  // Count byte-complete pulses
  always @(posedge clock_in) begin
    if (rx_valid_out === 1'b1) begin
      rx_count++;
    end
  end

  // ****************************************
  // Compare and helper tasks
  // ****************************************
  task automatic check_bit(input string what, input logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", what, exp, got);
      err_count++;
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // Count clock edges until a level shows, up to a limit
  task automatic wait_for(ref logic sig, input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge clock_in);
      #1;
      n++;
    end
  endtask

  // Frame carrying one operation request, Mode 3 idle
  task automatic op_frame(input op_t op);
    u_host.start_frame(1'b1);
    @(posedge clock_in);
    #1;
    op_req_in = '{valid: 1'b1, code: op};
    @(posedge clock_in);
    #1;
    op_req_in.valid = 1'b0;
    u_host.end_frame(1'b1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Values right after reset
  task automatic test_reset();
    check_bit("mode3 after reset", 1'b1, mode3_out);
    check_bit("output enable idle", 1'b0, so_oe_out);
    check_bit("busy_n after reset", 1'b1, busy_n_out);
    check_bit("protect after reset", 1'b0, protect_out);
    check_bit("power down after reset", 1'b0, power_down_out);
    $display("test reset done");
  endtask

  // Byte traffic in Mode 0 then Mode 3, idle clocks ignored
  task automatic test_link();
    logic [7:0] r;
    rx_count = 0;
    u_host.idle_clocks(6);
    check_bit("oe while deselected", 1'b0, so_oe_out);
    tx_byte_in = 8'h3C;
    u_host.start_frame(1'b0);
    check_bit("mode after low idle", 1'b0, mode3_out);
    u_host.xfer(8'hA5, r);
    check_byte("received byte", 8'hA5, rx_byte_out);
    check_bit("oe while selected", 1'b1, so_oe_out);
    u_host.xfer(8'h96, r);
    check_byte("sent byte mode 0", 8'h3C, r);
    check_byte("second received", 8'h96, rx_byte_out);
    u_host.end_frame(1'b0);
    repeat (10) @(posedge clock_in);
    check_bit("oe after deselect", 1'b0, so_oe_out);
    check_byte("byte count", 8'h02, 8'(rx_count));
    tx_byte_in = 8'hC3;
    u_host.start_frame(1'b1);
    check_bit("mode after high idle", 1'b1, mode3_out);
    u_host.xfer(8'h5A, r);
    check_byte("sent byte mode 3", 8'hC3, r);
    check_byte("received mode 3", 8'h5A, rx_byte_out);
    u_host.end_frame(1'b1);
    $display("test link done");
  endtask

  // Every self-timed operation: busy start and length
  task automatic test_ops();
    op_t ops[8] = '{OP_XFR, OP_COMP, OP_ERASE_PROG, OP_PROG,
      OP_PAGE_ERASE, OP_BLOCK_ERASE, OP_SECTOR_ERASE, OP_CHIP_ERASE};
    int lim[8] = '{XFR_T, XFR_T, EP_T, P_T, PE_T, BE_T, SE_T, CE_T};
    int n;
    int m;
    for (int i = 0; i < 8; i++) begin
      op_frame(ops[i]);
      wait_for(busy_n_out, 1'b0, 20, n);
      check_bit("busy start", 1'b1, n <= CSB_CYC);
      wait_for(busy_n_out, 1'b1, lim[i] + 20, m);
      check_bit("busy end bound", 1'b1, n + m <= lim[i]);
      check_bit("busy held", 1'b1, n + m >= lim[i] - 12);
      repeat (5) @(posedge clock_in);
    end
    $display("test ops done");
  endtask

  // Write protect on, program refused, protect off
  task automatic test_protect();
    int n;
    @(posedge clock_in);
    #1;
    wp_n_in = 1'b0;
    wait_for(protect_out, 1'b1, WPE_CYC + 20, n);
    check_bit("protect on time", 1'b1, n <= WPE_CYC);
    op_frame(OP_PROG);
    repeat (20) @(posedge clock_in);
    check_bit("protected busy_n", 1'b1, busy_n_out);
    @(posedge clock_in);
    #1;
    wp_n_in = 1'b1;
    wait_for(protect_out, 1'b0, WPE_CYC + 20, n);
    check_bit("protect off time", 1'b1, n <= WPE_CYC);
    $display("test protect done");
  endtask

  // Deep power-down entry and resume times
  task automatic test_power_down();
    int n;
    op_frame(OP_DPD);
    wait_for(power_down_out, 1'b1, EDPD_CYC + 20, n);
    check_bit("enter power down", 1'b1, n <= EDPD_CYC);
    op_frame(OP_RESUME);
    wait_for(power_down_out, 1'b0, RDPD_CYC + 20, n);
    check_bit("resume standby", 1'b1, n <= RDPD_CYC);
    $display("test power down done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    repeat (5) @(posedge clock_in);
    test_reset();
    test_link();
    test_ops();
    test_protect();
    test_power_down();
    complete_run();
  end

  // Cut a hang well past the expected run of about 53 us
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule // serial_flash_link_timing_tb_top
